/* shared/sad_pkg.sv */
// Package of constants and types for the servo alarm detector
package sad_pkg;

    // ****************************************
    // APB register map
    // ****************************************
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_CLEAR    = 8'h04;
    localparam logic [7:0] ADDR_ENABLE   = 8'h08;
    localparam logic [7:0] ADDR_ACTIVE   = 8'h0C;
    localparam logic [7:0] ADDR_OVFLVL   = 8'h10;
    localparam logic [7:0] ADDR_SOFFTHR  = 8'h14;
    localparam logic [7:0] ADDR_SPDLIM   = 8'h18;
    localparam logic [7:0] ADDR_CYCMIN   = 8'h1C;
    localparam logic [7:0] ADDR_CYCMAX   = 8'h20;
    localparam logic [7:0] ADDR_RESET    = 8'h24;
    localparam logic [7:0] ADDR_CODE     = 8'h28;

    // ****************************************
    // Alarm indices and codes
    // ****************************************
    localparam int NUM_ALM = 12;
    localparam int I_C92 = 0;
    localparam int I_CA0 = 1;
    localparam int I_CB0 = 2;
    localparam int I_CC0 = 3;
    localparam int I_D00 = 4;
    localparam int I_D01 = 5;
    localparam int I_D02 = 6;
    localparam int I_E40 = 7;
    localparam int I_E60 = 8;
    localparam int I_E61 = 9;
    localparam int I_ED1 = 10;
    localparam int I_F50 = 11;

    localparam logic [11:0] CODE_NONE = 12'h000;
    localparam logic [11:0] CODE_TAB [NUM_ALM] = '{
        12'hC92, 12'hCA0, 12'hCB0, 12'hCC0, 12'hD00, 12'hD01,
        12'hD02, 12'hE40, 12'hE60, 12'hE61, 12'hED1, 12'hF50};
    // Stop group two bits; the rest stop with group one
    localparam logic [11:0] GROUP_TWO_MASK = 12'h0_7C0;
    // Resettable alarms; encoder faults are latched until power cycle
    localparam logic [11:0] RESETTABLE_MASK = 12'h0_FF0;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [31:0] OVFLVL_RST  = 32'h0000_1000;
    localparam logic [31:0] SOFFTHR_RST = 32'h0000_0800;
    localparam logic [31:0] SPDLIM_RST  = 32'h0000_0100;
    localparam logic [31:0] CYCMIN_RST  = 32'h0000_0064;
    localparam logic [31:0] CYCMAX_RST  = 32'h0000_2710;
    localparam logic [3:0]  RXERR_LIMIT = 4'h2;
    localparam int          F50_TIME_US = 10;
    localparam int          CLK_MHZ     = 100;
    localparam logic [15:0] F50_CYCLES  = 16'(F50_TIME_US * CLK_MHZ);

    typedef struct packed {
        logic       encTimerFault;
        logic       encParamBad;
        logic       encEchoMismatch;
        logic       multiturnMismatch;
        logic       busRxError;
        logic       busCycleTick;
        logic       cmdTimeout;
        logic       motorMoved;
        logic       motorPowered;
        logic       driveReady;
    } sad_evt_s;

endpackage : sad_pkg

/* verilog/sad_cycle_check.sv */
// Fieldbus cycle interval measurement and jitter check
`timescale 1ns/1ps
module sad_cycle_check
    import sad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    output logic             jitter,
    output logic [31:0]      period
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [31:0] last;
        logic        seen;
        logic        jit;
    } sad_cyc_s;

    sad_cyc_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.jit = 1'b0;
        st_d.cnt = st_q.cnt + 32'h0000_0001;
        if (tick) begin
            // Two ticks establish a reference interval first
            if (st_q.seen && st_q.last != 32'h0000_0000
                && st_q.cnt != st_q.last) begin
                st_d.jit = 1'b1;
            end
            st_d.last = st_q.seen ? st_q.cnt : 32'h0000_0000;
            st_d.seen = 1'b1;
            st_d.cnt  = 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign jitter = st_q.jit;
    assign period = st_q.last;
endmodule : sad_cycle_check

/* verilog/sad_alarm_unit.sv */
// Servo alarm detector top with APB register file
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Encoder timer fault raises C92, group one, not resettable.
// - Invalid encoder parameters raise CA0, group one, not resettable.
// - Encoder echo mismatch raises Cb0, group one, not resettable.
// - Multiturn limit mismatch raises CC0, group one, not resettable.
// - Error above overflow level while powered raises d00, group one.
// - Power-on with error above servo-off threshold raises d01.
// - Power-on with error caps speed; overflow while capped raises d02.
// - Transmission cycle out of range raises E40, group two.
// - Repeated consecutive reception errors raise E60, group two.
// - Varying transmission cycle interval raises E61, group two.
// - Command timeout raises Ed1, group two, resettable.
// - Servo-on accepted but motor idle or unpowered raises F50.
// - Any active alarm drives the alarm output high.
module sad_alarm_unit
    import sad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire sad_evt_s    evt,
    input  wire logic        motorPowerOnCommand,
    input  wire logic [31:0] positionError,
    output logic             alarmOutput,
    output logic             stopGroupOne,
    output logic             stopGroupTwo,
    output logic             speedCapActive,
    output logic [31:0]      speedLimit,
    output logic             irq
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {PW_OFF, PW_CAPPED, PW_ON} sad_pwr_e;

    typedef struct packed {
        logic [11:0] active;
        logic [11:0] status;
        logic [11:0] enable;
        logic [31:0] ovfLevel;
        logic [31:0] soffThr;
        logic [31:0] spdLim;
        logic [31:0] cycMin;
        logic [31:0] cycMax;
        logic [3:0]  rxErrCnt;
        logic [15:0] f50Cnt;
        logic        powerPrev;
        sad_pwr_e    pwr;
        logic [31:0] rdata;
        logic [11:0] code;
    } sad_state_s;

    sad_state_s st_q, st_d;
    logic        cycJitter;
    logic [31:0] cycPeriod;
    logic        wrEn;
    logic        rdEn;
    logic [11:0] raise;

    sad_cycle_check uCycle (
        .clk    (clk),
        .rst_n  (rst_n),
        .tick   (evt.busCycleTick),
        .jitter (cycJitter),
        .period (cycPeriod)
    );

    function automatic logic [11:0] firstCode(input logic [11:0] act);
        logic [11:0] c;
        c = CODE_NONE;
        for (int i = NUM_ALM - 1; i >= 0; i--) begin
            if (act[i]) begin
                c = CODE_TAB[i];
            end
        end
        return c;
    endfunction : firstCode

    function automatic logic mapped(input logic [7:0] a);
        return a <= ADDR_CODE && a[1:0] == 2'b00;
    endfunction : mapped

    assign wrEn = psel && penable && pwrite && mapped(paddr);
    assign rdEn = psel && !penable && !pwrite;

    // ****************************************
    // Detection and registers
    // ****************************************
    always_comb begin
        st_d = st_q;
        raise = '0;
        raise[I_C92] = evt.encTimerFault;
        raise[I_CA0] = evt.encParamBad;
        raise[I_CB0] = evt.encEchoMismatch;
        raise[I_CC0] = evt.multiturnMismatch;
        raise[I_D00] = st_q.pwr == PW_ON
                       && positionError > st_q.ovfLevel;
        raise[I_D01] = motorPowerOnCommand && !st_q.powerPrev
                       && positionError > st_q.soffThr;
        raise[I_D02] = st_q.pwr == PW_CAPPED
                       && positionError > st_q.ovfLevel;
        raise[I_E40] = cycPeriod != 32'h0000_0000
                       && (cycPeriod < st_q.cycMin
                           || cycPeriod > st_q.cycMax);
        raise[I_E60] = evt.busRxError
                       && st_q.rxErrCnt >= RXERR_LIMIT;
        raise[I_E61] = cycJitter;
        raise[I_ED1] = evt.cmdTimeout;
        raise[I_F50] = st_q.f50Cnt >= F50_CYCLES;

        // Consecutive reception errors; any clean frame restarts count
        if (evt.busCycleTick && !evt.busRxError) begin
            st_d.rxErrCnt = 4'h0;
        end else if (evt.busRxError && st_q.rxErrCnt != 4'hF) begin
            st_d.rxErrCnt = st_q.rxErrCnt + 4'h1;
        end

        // Power sequencing with residual error speed cap
        st_d.powerPrev = motorPowerOnCommand;
        case (st_q.pwr)
            PW_OFF: begin
                if (motorPowerOnCommand) begin
                    st_d.pwr = positionError != 32'h0000_0000
                               ? PW_CAPPED : PW_ON;
                end
            end
            PW_CAPPED: begin
                if (!motorPowerOnCommand) begin
                    st_d.pwr = PW_OFF;
                end else if (positionError == 32'h0000_0000) begin
                    st_d.pwr = PW_ON;
                end
            end
            PW_ON: begin
                if (!motorPowerOnCommand) begin
                    st_d.pwr = PW_OFF;
                end
            end
            default: st_d.pwr = PW_OFF;
        endcase

        // Servo-on accepted with drive ready but no motion or no power
        if (st_q.pwr != PW_OFF && evt.driveReady
            && !(evt.motorMoved && evt.motorPowered)) begin
            if (st_q.f50Cnt != F50_CYCLES) begin
                st_d.f50Cnt = st_q.f50Cnt + 16'h0001;
            end
        end else begin
            st_d.f50Cnt = 16'h0000;
        end

        // Register writes; hardware set wins over software clear
        if (wrEn) begin
            case (paddr)
                ADDR_CLEAR:   st_d.status = st_q.status & ~pwdata[11:0];
                ADDR_ENABLE:  st_d.enable = pwdata[11:0];
                ADDR_OVFLVL:  st_d.ovfLevel = pwdata;
                ADDR_SOFFTHR: st_d.soffThr = pwdata;
                ADDR_SPDLIM:  st_d.spdLim = pwdata;
                ADDR_CYCMIN:  st_d.cycMin = pwdata;
                ADDR_CYCMAX:  st_d.cycMax = pwdata;
                ADDR_RESET: begin
                    // Non-resettable alarms stay; empty reset is a no-op
                    st_d.active = st_q.active
                        & ~(pwdata[11:0] & RESETTABLE_MASK);
                end
                default: st_d.rdata = st_q.rdata;
            endcase
        end
        st_d.status = st_d.status | raise;
        st_d.active = st_d.active | raise;
        st_d.code = firstCode(st_d.active);

        if (rdEn) begin
            case (paddr)
                ADDR_STATUS:  st_d.rdata = {20'h0_0000, st_q.status};
                ADDR_ENABLE:  st_d.rdata = {20'h0_0000, st_q.enable};
                ADDR_ACTIVE:  st_d.rdata = {20'h0_0000, st_q.active};
                ADDR_OVFLVL:  st_d.rdata = st_q.ovfLevel;
                ADDR_SOFFTHR: st_d.rdata = st_q.soffThr;
                ADDR_SPDLIM:  st_d.rdata = st_q.spdLim;
                ADDR_CYCMIN:  st_d.rdata = st_q.cycMin;
                ADDR_CYCMAX:  st_d.rdata = st_q.cycMax;
                ADDR_CODE:    st_d.rdata = {20'h0_0000, st_q.code};
                default:      st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q          <= '0;
            st_q.ovfLevel <= OVFLVL_RST;
            st_q.soffThr  <= SOFFTHR_RST;
            st_q.spdLim   <= SPDLIM_RST;
            st_q.cycMin   <= CYCMIN_RST;
            st_q.cycMax   <= CYCMAX_RST;
            st_q.pwr      <= PW_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata  = st_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign alarmOutput  = |st_q.active;
    assign stopGroupTwo = |(st_q.active & GROUP_TWO_MASK);
    assign stopGroupOne = |(st_q.active & ~GROUP_TWO_MASK);
    assign speedCapActive = st_q.pwr == PW_CAPPED;
    assign speedLimit   = st_q.spdLim;
    assign irq = |(st_q.status & st_q.enable);

    // ****************************************
    // Assertions
    // ****************************************
    property p_enc_latch;
        @(posedge clk) disable iff (!rst_n)
        evt.encTimerFault |=> st_q.active[I_C92] [*3];
    endproperty
    a_enc_latch: assert property (p_enc_latch)
        else $error("C92 not latched");

    property p_param;
        @(posedge clk) disable iff (!rst_n)
        evt.encParamBad |=> st_q.code != CODE_NONE && stopGroupOne;
    endproperty
    a_param: assert property (p_param)
        else $error("CA0 without stop");

    property p_echo;
        @(posedge clk) disable iff (!rst_n)
        st_q.active[I_CB0] |=> st_q.active[I_CB0];
    endproperty
    a_echo: assert property (p_echo)
        else $error("Cb0 was reset");

    property p_mturn;
        @(posedge clk) disable iff (!rst_n)
        evt.multiturnMismatch |=> st_q.active[I_CC0] && alarmOutput;
    endproperty
    a_mturn: assert property (p_mturn)
        else $error("CC0 missed");

    property p_ovf;
        @(posedge clk) disable iff (!rst_n)
        st_q.pwr == PW_ON && positionError > st_q.ovfLevel
        |=> st_q.active[I_D00];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("d00 missed");

    property p_cap;
        @(posedge clk) disable iff (!rst_n)
        $rose(motorPowerOnCommand) && st_q.pwr == PW_OFF
        && positionError != 32'h0000_0000 |=> speedCapActive;
    endproperty
    a_cap: assert property (p_cap)
        else $error("Speed cap missing");

    property p_grp2;
        @(posedge clk) disable iff (!rst_n)
        cycJitter |=> stopGroupTwo;
    endproperty
    a_grp2: assert property (p_grp2)
        else $error("E61 not group two");

    property p_idle;
        @(posedge clk) disable iff (!rst_n)
        !alarmOutput |-> st_q.code == CODE_NONE && !stopGroupOne
                         && !stopGroupTwo;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Stop without alarm");

    property p_alm;
        @(posedge clk) disable iff (!rst_n)
        evt.cmdTimeout |=> alarmOutput;
    endproperty
    a_alm: assert property (p_alm)
        else $error("Alarm output not raised");
endmodule : sad_alarm_unit

/* dv/sad_host_model.sv */
// Host controller model: cycle ticks, reception errors, timeouts
`timescale 1ns/1ps
module sad_host_model
    import sad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] period,
    input  wire logic        wobble,
    input  wire logic        rxBad,
    input  wire logic        cmdLate,
    output logic             tick,
    output logic             rxErr,
    output logic             cmdTo
);
    logic [15:0] cnt_q;
    logic        alt_q;
    logic [15:0] lim;
    // Alternate period and period+1 so the interval fluctuates
    assign lim = (wobble && alt_q) ? period : period - 16'h0001;
    always_ff @(posedge clk) begin
        tick  <= 1'b0;
        rxErr <= 1'b0;
        cmdTo <= 1'b0;
        if (!rst_n || period == 16'h0000) begin
            cnt_q <= 16'h0000;
            alt_q <= 1'b0;
        end else if (cnt_q >= lim) begin
            cnt_q <= 16'h0000;
            alt_q <= ~alt_q;
            tick  <= 1'b1;
            rxErr <= rxBad;
            cmdTo <= cmdLate;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : sad_host_model

/* dv/test_servo_alarm_detector.sv */
// Self-checking testbench for the servo alarm detector
`timescale 1ns/1ps
module test_servo_alarm_detector
    import sad_pkg::*;
;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, posErr, speedLimit, rd;
    sad_evt_s    evt, evtBus;
    logic        pwrOn, alarmOutput, stopGroupOne, stopGroupTwo;
    logic        speedCapActive, irq, wobble, rxBad, cmdLate;
    logic        tick, rxErr, cmdTo, err;
    logic [15:0] period;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always_comb begin
        evtBus              = evt;
        evtBus.busCycleTick = tick;
        evtBus.busRxError   = rxErr;
        evtBus.cmdTimeout   = cmdTo;
    end

    sad_alarm_unit uut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evtBus),
        .motorPowerOnCommand(pwrOn), .positionError(posErr),
        .alarmOutput(alarmOutput), .stopGroupOne(stopGroupOne),
        .stopGroupTwo(stopGroupTwo), .speedCapActive(speedCapActive),
        .speedLimit(speedLimit), .irq(irq));

    sad_host_model host (.clk(clk), .rst_n(rst_n), .period(period),
        .wobble(wobble), .rxBad(rxBad), .cmdLate(cmdLate), .tick(tick),
        .rxErr(rxErr), .cmdTo(cmdTo));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdChk(input string nm, input logic [7:0] a,
                         input logic [31:0] msk, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd & msk);
    endtask : rdChk

    task automatic doReset();
        @(posedge clk);
        rst_n   <= 1'b0;
        evt     <= '0;
        pwrOn   <= 1'b0;
        posErr  <= 32'h0000_0000;
        period  <= 16'h0000;
        wobble  <= 1'b0;
        rxBad   <= 1'b0;
        cmdLate <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : doReset

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {rst_n, psel, penable, pwrite, pwrOn} = 5'h00;
        {wobble, rxBad, cmdLate} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        posErr = 32'h0000_0000;
        period = 16'h0000;
        evt = '0;
        doReset();
        rdChk("code", ADDR_CODE, 32'hFFFF_FFFF, 32'(CODE_NONE));
        rdChk("ovf", ADDR_OVFLVL, 32'hFFFF_FFFF, OVFLVL_RST);
        rdChk("soff", ADDR_SOFFTHR, 32'hFFFF_FFFF, SOFFTHR_RST);
        apb(1'b1, ADDR_RESET, 32'h0000_0FFF);
        rdChk("idle", ADDR_ACTIVE, 32'hFFFF_FFFF, 32'h0000_0000);
        chk("stop", 32'h0,
            32'({stopGroupOne, stopGroupTwo, alarmOutput}));
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h1, {31'h0, err});
        chk("unmappedData", 32'h0, rd);
        // Output is registered, so look one edge after the write lands
        apb(1'b1, ADDR_SPDLIM, 32'h0000_0080);
        @(posedge clk);
        chk("spdLim", 32'h0000_0080, speedLimit);
        apb(1'b1, ADDR_CYCMAX, 32'h0000_0040);
        rdChk("cycMax", ADDR_CYCMAX, 32'hFFFF_FFFF, 32'h0000_0040);
        $display("Test idle done");
        // Encoder faults stay latched, so each needs its own reset
        for (int i = 0; i < 4; i++) begin
            doReset();
            evt[9-i] <= 1'b1;
            repeat (2) @(posedge clk);
            evt[9-i] <= 1'b0;
            apb(1'b1, ADDR_RESET, 32'h0000_0FFF);
            rdChk("enc", ADDR_ACTIVE, 32'hFFF, 32'(1) << i);
            rdChk("encCode", ADDR_CODE, 32'hFFF, 32'(CODE_TAB[i]));
            chk("encStop", 32'h2, 32'({stopGroupOne, stopGroupTwo}));
            chk("encOut", 32'h1, {31'h0, alarmOutput});
        end
        $display("Test encoder done");
        doReset();
        pwrOn <= 1'b1;
        apb(1'b1, ADDR_OVFLVL, 32'h0000_0200);
        posErr <= 32'h0000_0200;
        repeat (3) @(posedge clk);
        rdChk("d00Edge", ADDR_ACTIVE, 32'h10, 32'h00);
        posErr <= 32'h0000_0201;
        repeat (3) @(posedge clk);
        rdChk("d00", ADDR_ACTIVE, 32'h10, 32'h10);
        chk("d00Stop", 32'h1, {31'h0, stopGroupOne});
        posErr <= 32'h0000_0000;
        apb(1'b1, ADDR_RESET, 32'h0000_0010);
        rdChk("d00Clr", ADDR_CODE, 32'hFFF, 32'h000);
        chk("d00Out", 32'h0, {31'h0, alarmOutput});
        $display("Test overflow done");
        doReset();
        posErr <= 32'h0000_0900;
        repeat (2) @(posedge clk);
        pwrOn <= 1'b1;
        repeat (3) @(posedge clk);
        rdChk("d01", ADDR_ACTIVE, 32'h60, 32'h20);
        chk("cap", 32'h1, {31'h0, speedCapActive});
        chk("capLim", SPDLIM_RST, speedLimit);
        posErr <= 32'h0000_1001;
        repeat (3) @(posedge clk);
        rdChk("d02", ADDR_ACTIVE, 32'h40, 32'h40);
        chk("d02Stop", 32'h1, {31'h0, stopGroupTwo});
        $display("Test servo on done");
        // Short cycle, rx errors, wobble, late command
        for (int k = 0; k < 4; k++) begin
            doReset();
            period  <= (k == 0) ? 16'h0032 : 16'h00C8;
            rxBad   <= (k == 1);
            wobble  <= (k == 2);
            cmdLate <= (k == 3);
            repeat (1000) @(posedge clk);
            rdChk("bus", ADDR_ACTIVE, 32'(1) << (7 + k),
                  32'(1) << (7 + k));
            chk("busStop", 32'h1, {31'h0, stopGroupTwo});
        end
        cmdLate <= 1'b0;
        period  <= 16'h0000;
        rdChk("sticky", ADDR_STATUS, 32'h400, 32'h400);
        apb(1'b1, ADDR_ENABLE, 32'h0000_0400);
        @(posedge clk);
        chk("irqOn", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
        @(posedge clk);
        chk("irqMask", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_ENABLE, 32'h0000_0400);
        apb(1'b1, ADDR_CLEAR, 32'h0000_0400);
        @(posedge clk);
        chk("irqClr", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_RESET, 32'h0000_0400);
        rdChk("ed1Clr", ADDR_ACTIVE, 32'h400, 32'h000);
        $display("Test fieldbus done");
        doReset();
        evt.driveReady <= 1'b1;
        pwrOn <= 1'b1;
        repeat (1100) @(posedge clk);
        rdChk("f50", ADDR_ACTIVE, 32'h800, 32'h800);
        chk("f50Stop", 32'h1, {31'h0, stopGroupOne});
        $display("Test cable done");
        tally_and_finish();
    end
endmodule : test_servo_alarm_detector
